//--- sbc_bus_peer.sv
`timescale 1ns/10ps
module sbc_bus_peer (
    output logic scl_p,
    output logic sda_p
);
    // Released lines read high through the pull-ups
    initial begin
        scl_p = 1'b1;
        sda_p = 1'b1;
    end
    task automatic start_c();
        sda_p = 1'b0;
        #160 scl_p = 1'b0;
    endtask
    // Data moves 40 ns after scl falls; long low phase leaves room for the ack
    task automatic send_byte(input logic [7:0] b);
        logic [8:0] d;
        d = {b, 1'b1};
        for (int i = 8; i >= 0; i--) begin
            #40 sda_p = d[i];
            #160 scl_p = 1'b1;
            #120 scl_p = 1'b0;
        end
    endtask
    task automatic stop_c();
        #40 sda_p = 1'b0;
        #160 scl_p = 1'b1;
        #120 sda_p = 1'b1;
    endtask
endmodule

//--- sbc_ctrl.sv
//Contract
// (R1) Writing stop trigger sets output latch high, then trigger self-clears; disable clears it.
// (R2) Writing start trigger clears output latch low, then trigger self-clears.
// (R3) Start-detected sets on bus start; clears on transfer start, disable, reset.
// (R4) Stop-detected sets on bus stop; clears on transfer start, mismatch, disable, reset.
// (R5) Manual acknowledge holds data low until next clock fall; transfer start/disable clear.
// (R6) Auto acknowledge disabled: no automatic ack, manual ack still works.
// (R7) Auto acknowledge enabled: ack driven from eighth clock fall of received byte.
// (R8) Hardware never clears the auto acknowledge enable.
// (R9) Software sets auto acknowledge enable before a transfer, not during.
// (R10) Eight-clock wait reception needs software manual acknowledge.
// (R11) Ack-detected sets when ack sampled on rising clock after transfer; clears likewise.
// (R12) Busy enable 0 lets data output drive; 1 releases it for reception.
// (R13) Busy ends on transfer start or address reception; busy enable stays set.
// (R14) Software sets busy enable when using address-match wakeup.
// (R15) Detected flags in bits 2, 3, 6 are read-only; writes ignored.
// (R16) Control register at ff61, triggers in bits 1 and 0, resets to 00.
// (R17) Channel enable low stops operation and clears flags and triggers.
`timescale 1ns/10ps
module sbc_ctrl
    import sbc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic channel_enable,
    input wire logic xfer_start,
    input wire logic addr_received,
    input wire logic addr_mismatch,
    input wire logic rx_byte,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic serial_data_output_latch,
    output logic busy
);
    typedef struct packed {
        sbc_ctrl_t ctrl;
        logic latch;
        logic busy;
        logic scl;
        logic sda;
        logic [3:0] clk_cnt;
        sbc_phase_t phase;
        logic rx;
        logic auto_ack;
        logic [7:0] rdata;
    } sbc_state_t;

    sbc_state_t s_q;
    sbc_state_t s_d;
    logic scl_s;
    logic sda_s;
    logic hit;
    logic scl_rise;
    logic scl_fall;

    sbc_pin_sync u_sync (
        .clk(clk),
        .rstn(rstn),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .scl_s(scl_s),
        .sda_s(sda_s)
    );

    assign hit = (addr == SBC_CTRL_ADDR); // R16
    assign scl_rise = scl_s && !s_q.scl;
    assign scl_fall = !scl_s && s_q.scl;

    always_comb begin
        s_d = s_q;
        s_d.scl = scl_s;
        s_d.sda = sda_s;
        if (rd && hit) begin
            s_d.rdata = s_q.ctrl;
        end
        // Bus conditions: data edge while clock high
        if (scl_s && s_q.scl && s_q.sda && !sda_s) begin
            s_d.ctrl.start_detected = 1'b1; // R3
            s_d.clk_cnt = 4'h0;
            s_d.phase = SBC_XFER;
        end
        if (scl_s && s_q.scl && !s_q.sda && sda_s) begin
            s_d.ctrl.stop_detected = 1'b1; // R4
            s_d.phase = SBC_IDLE;
        end
        // Clock counting: ninth rising edge samples ack
        if (scl_rise && s_q.phase != SBC_IDLE) begin
            s_d.clk_cnt = 4'(s_q.clk_cnt + 4'h1);
            if (4'(s_q.clk_cnt + 4'h1) == SBC_ACK_CLOCK) begin
                s_d.phase = SBC_ACKP;
                if (!sda_s) begin
                    s_d.ctrl.ack_detected = 1'b1; // R11
                end
            end
        end
        if (rx_byte) begin
            s_d.rx = 1'b1;
        end
        // Manual ack lasts until the next falling clock edge
        if (scl_fall) begin
            s_d.ctrl.manual_acknowledge = 1'b0; // R5
            if (s_q.auto_ack) begin
                s_d.auto_ack = 1'b0;
            end else if (s_q.clk_cnt == 4'h8 && s_q.rx
                         && s_q.ctrl.auto_acknowledge_enable) begin
                s_d.auto_ack = 1'b1; // R7
                s_d.rx = 1'b0;
            end
            if (s_q.phase == SBC_ACKP) begin
                s_d.clk_cnt = 4'h0;
                s_d.phase = SBC_XFER;
            end
        end
        if (wr && hit) begin
            // Flag bits are not writable; hardware never clears auto ack enable
            s_d.ctrl = (s_d.ctrl & ~SBC_WR_MASK) | (wdata & SBC_WR_MASK); // R15 R8
        end
        // Triggers act and self-clear the cycle after they are written
        if (s_q.ctrl.stop_trigger) begin
            s_d.latch = 1'b1; // R1
            s_d.ctrl.stop_trigger = 1'b0; // R1
        end
        if (s_q.ctrl.start_trigger) begin
            s_d.latch = 1'b0; // R2
            s_d.ctrl.start_trigger = 1'b0; // R2
        end
        if (xfer_start) begin
            s_d.ctrl.start_detected = 1'b0; // R3
            s_d.ctrl.stop_detected = 1'b0; // R4
            s_d.ctrl.ack_detected = 1'b0; // R11
            s_d.ctrl.manual_acknowledge = 1'b0; // R5
            s_d.busy = 1'b0; // R13
        end
        if (addr_received) begin
            s_d.busy = 1'b0; // R13
        end
        if (addr_mismatch) begin
            s_d.ctrl.stop_detected = 1'b0; // R4
        end
        if (wr && hit && wdata[SBC_B_BUSY]) begin
            s_d.busy = 1'b1;
        end
        if (!channel_enable) begin
            s_d.ctrl.stop_trigger = 1'b0; // R17
            s_d.ctrl.start_trigger = 1'b0; // R17
            s_d.ctrl.start_detected = 1'b0; // R17
            s_d.ctrl.stop_detected = 1'b0; // R17
            s_d.ctrl.ack_detected = 1'b0; // R17
            s_d.ctrl.manual_acknowledge = 1'b0; // R17
            s_d.auto_ack = 1'b0;
            s_d.rx = 1'b0;
            s_d.phase = SBC_IDLE;
            s_d.clk_cnt = 4'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.ctrl <= SBC_CTRL_RESET; // R16
            s_q.latch <= 1'b1;
            s_q.scl <= 1'b1;
            s_q.sda <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Open-drain: only a low is ever driven; busy enable releases the latch path
    always_comb begin
        sda_o = 1'b0;
        sda_oe = 1'b0;
        if (channel_enable) begin
            if (s_q.ctrl.manual_acknowledge || s_q.auto_ack) begin
                sda_oe = 1'b1; // R6
            end else if (!s_q.ctrl.busy_enable && !s_q.latch) begin
                sda_oe = 1'b1; // R12
            end
        end
    end

    assign rdata = s_q.rdata;
    assign serial_data_output_latch = s_q.latch;
    assign busy = s_q.busy;
endmodule

//--- sbc_pin_sync.sv
`timescale 1ns/10ps
module sbc_pin_sync
    import sbc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_s,
    output logic sda_s
);
    sbc_sync_t st_q;
    sbc_sync_t st_d;
    logic scl_hold_q;
    logic sda_hold_q;

    always_comb begin
        st_d = st_q;
        st_d.scl = {st_q.scl[1:0], scl_i};
        st_d.sda = {st_q.sda[1:0], sda_i};
    end

    // Level moves only when the last two stages agree; first stage feeds only the second
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_q <= '1;
            scl_hold_q <= 1'b1;
            sda_hold_q <= 1'b1;
        end else begin
            st_q <= st_d;
            if (st_q.scl[2] == st_q.scl[1]) begin
                scl_hold_q <= st_q.scl[2];
            end
            if (st_q.sda[2] == st_q.sda[1]) begin
                sda_hold_q <= st_q.sda[2];
            end
        end
    end

    assign scl_s = scl_hold_q;
    assign sda_s = sda_hold_q;
endmodule

//--- sbc_pkg.sv
package sbc_pkg;
    localparam logic [15:0] SBC_CTRL_ADDR = 16'hff61;
    localparam logic [7:0] SBC_CTRL_RESET = 8'h00;
    localparam int SBC_B_STOP_TRIG = 0;
    localparam int SBC_B_START_TRIG = 1;
    localparam int SBC_B_STOP_DET = 2;
    localparam int SBC_B_START_DET = 3;
    localparam int SBC_B_MAN_ACK = 4;
    localparam int SBC_B_AUTO_ACK = 5;
    localparam int SBC_B_ACK_DET = 6;
    localparam int SBC_B_BUSY = 7;
    localparam logic [7:0] SBC_WR_MASK = 8'hb3;
    localparam logic [3:0] SBC_ACK_CLOCK = 4'h9;

    typedef struct packed {
        logic [2:0] scl;
        logic [2:0] sda;
    } sbc_sync_t;

    typedef struct packed {
        logic busy_enable;
        logic ack_detected;
        logic auto_acknowledge_enable;
        logic manual_acknowledge;
        logic start_detected;
        logic stop_detected;
        logic start_trigger;
        logic stop_trigger;
    } sbc_ctrl_t;

    typedef enum logic [1:0] {
        SBC_IDLE = 2'b00,
        SBC_XFER = 2'b01,
        SBC_ACKP = 2'b11
    } sbc_phase_t;
endpackage

//--- sbc_properties.sv
`timescale 1ns/10ps
module sbc_properties
    import sbc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic channel_enable,
    input wire logic xfer_start,
    input wire logic addr_received,
    input wire logic addr_mismatch,
    input wire logic rx_byte,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic serial_data_output_latch,
    input wire logic busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire wc = wr && addr == SBC_CTRL_ADDR && channel_enable;
    wire rc = rd && addr == SBC_CTRL_ADDR;
    a_stop_latch:
        assert property (wc && wdata == 8'h01 |-> ##2 serial_data_output_latch) else $error("latch low");
    a_start_latch:
        assert property (wc && wdata == 8'h02 |-> ##2 !serial_data_output_latch) else $error("latch high");
    a_manual_ack:
        assert property (wc && wdata == 8'h10 |-> ##[1:2] sda_oe) else $error("no manual ack");
    a_busy_ends:
        assert property (xfer_start || addr_received |=> !busy) else $error("busy kept");
    a_reset_vals:
        assert property ($rose(rstn) |-> serial_data_output_latch && !busy && rdata == 8'h00)
        else $error("bad reset state");
    a_xfer_clear:
        assert property (xfer_start ##2 rc |=> !rdata[6] && rdata[4:2] == 3'h0)
        else $error("flags kept");
    a_off_clear:
        assert property ($past(!channel_enable) && !channel_enable && rc |=> rdata[4:0] == 5'h00)
        else $error("disable kept bits");
    a_rdata_hold:
        assert property (!rd |=> $stable(rdata)) else $error("rdata moved");
endmodule
bind sbc_ctrl sbc_properties u_props (.*);

//--- tb_top.sv
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
    $display("Error t=%0t got %h exp %h", $time, a, e); end end
module tb_top import sbc_pkg::*; ;
    localparam logic [15:0] A = SBC_CTRL_ADDR;
    logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, ce = 1'b1, rd_seen = 1'b0;
    logic xs = 1'b0, ar = 1'b0, am = 1'b0, rx = 1'b0, sda_oe, scl_p, sda_p, lat, bsy;
    logic [7:0] e_v;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00, w, rdata;
    logic [7:0] exp_q[$];
    int num_errors = 0, checked = 0;
    sbc_bus_peer peer (.scl_p(scl_p), .sda_p(sda_p));
    sbc_ctrl DUT (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .channel_enable(ce), .xfer_start(xs), .addr_received(ar),
        .addr_mismatch(am), .rx_byte(rx), .scl_i(scl_p), .sda_i(sda_p & ~sda_oe),
        .sda_o(), .sda_oe(sda_oe), .serial_data_output_latch(lat), .busy(bsy));
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        if (rd_seen) begin
            // Pop once; the macro reads its arguments twice
            e_v = exp_q.pop_front();
            `CHK(rdata, e_v)
        end
        rd_seen <= rd;
    end
    task automatic wreg(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rreg(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        exp_q.push_back(e);
        @(negedge clk);
        rd = 1'b0;
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    task automatic frame();
        peer.start_c();
        pulse(rx);
        peer.send_byte(8'($urandom));
        peer.stop_c();
        repeat (8) @(negedge clk);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'hf3968f52));
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        rreg(A, SBC_CTRL_RESET);
        // Bit 7 set and bit 4 clear so the data line stays released
        w = (8'($urandom) & 8'hef) | 8'h80;
        wreg(A, w);
        rreg(A, w & 8'ha0);
        wreg(16'hff60, 8'h00);
        rreg(16'hff60, w & 8'ha0);
        rreg(A, w & 8'ha0);
        wreg(A, 8'h81);
        wreg(A, 8'h20);
        frame();
        rreg(A, 8'h6c);
        pulse(xs);
        rreg(A, 8'h20);
        wreg(A, 8'h00);
        frame();
        rreg(A, 8'h0c);
        pulse(am);
        rreg(A, 8'h08);
        wreg(A, 8'h02);
        @(negedge clk);
        `CHK(lat, 1'b0)
        wreg(A, 8'h01);
        wreg(A, 8'h10);
        wreg(A, 8'ha0);
        `CHK(bsy, 1'b1)
        pulse(ar);
        `CHK(bsy, 1'b0)
        @(negedge clk);
        ce = 1'b0;
        rreg(A, 8'ha0);
        ce = 1'b1;
        repeat (4) @(negedge clk);
        if (exp_q.size() != 0)
            num_errors++;
        end_of_test();
    end
endmodule
